// >>> common/power_stage_defines.svh
`ifndef POWER_STAGE_DEFINES_SVH
`define POWER_STAGE_DEFINES_SVH
`define DT4_EXTRA 12'h002
`define CNT_ONE 12'h001
`define CNT_RST 12'h000
`define FRAME_RST 4'h0
`define FLAG_RST 3'h0
`define FLAG_OVF 0
`define FLAG_FAULT 1
`define FLAG_CAPT 2
`define FWM_HI 15
`define FWM_LO 12
`endif

// >>> common/power_stage_pkg.sv
package power_stage_pkg;
	typedef enum logic [1:0] {
		M_FOUR   = 2'h0,
		M_TWO    = 2'h1,
		M_ONE    = 2'h2,
		M_CENTER = 2'h3
	} run_mode_t;
	typedef enum logic [4:0] {
		S_STOP = 5'h01,
		S_R0   = 5'h02,
		S_R1   = 5'h04,
		S_R2   = 5'h08,
		S_R3   = 5'h10
	} ramp_state_t;
	typedef struct packed {
		logic [11:0] set_a;
		logic [11:0] reset_a;
		logic [11:0] set_b;
		logic [15:0] reset_b;
	} timing_set_t;
	typedef struct packed {
		ramp_state_t st;
		logic [11:0] cnt;
		timing_set_t act;
		run_mode_t   mode;
		logic [3:0]  frame;
		logic [11:0] capture;
		logic [2:0]  flags;
		logic        out_a;
		logic        out_b;
		logic        sync_out;
		logic        adc_sync;
		logic        em_meta;
		logic        em_sync;
		logic        fuse_hiz;
	} stage_state_t;
	typedef struct packed {
		logic pin_meta;
		logic pin_sync;
		logic cmp_meta;
		logic cmp_sync;
		logic prev;
		logic evt;
	} input_state_t;
	typedef struct packed {
		logic level;
		logic oe;
	} drive_state_t;
endpackage

// >>> verilog/stage_input_module.sv
`timescale 1ns/100ps
module stage_input_module
	import power_stage_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic ce_i,
	input  wire logic pin_i,
	input  wire logic comp_i,
	input  wire logic src_sel_i,
	input  wire logic rising_i,
	output logic      active_o,
	output logic      event_o
);
	input_state_t r;
	input_state_t next_r;
	logic         lvl;

	////////////////////////////////////////////////////////////////////////////////
	// both sources are asynchronous, so each gets two flops
	always_comb begin
		next_r          = r;
		next_r.pin_meta = pin_i;
		next_r.pin_sync = r.pin_meta;
		next_r.cmp_meta = comp_i;
		next_r.cmp_sync = r.cmp_meta;
		lvl             = (src_sel_i ? r.cmp_sync : r.pin_sync) ~^ rising_i;
		next_r.prev     = lvl;
		next_r.evt      = lvl & ~r.prev;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r <= '0;
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	assign active_o = r.prev;
	assign event_o  = r.evt;
endmodule

// >>> verilog/stage_output_driver.sv
`timescale 1ns/100ps
module stage_output_driver
	import power_stage_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic ce_i,
	input  wire logic level_i,
	input  wire logic active_high_i,
	input  wire logic emergency_i,
	input  wire logic hiz_i,
	output logic      out_o,
	output logic      oe_o
);
	drive_state_t r;
	drive_state_t next_r;

	always_comb begin
		next_r       = r;
		// emergency drops to inactive level whatever the polarity
		next_r.level = (level_i & ~emergency_i) ~^ active_high_i;
		next_r.oe    = ~(emergency_i & hiz_i);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r <= '{level: 1'b0, oe: 1'b1};
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	assign out_o = r.level;
	assign oe_o  = r.oe;
endmodule

// >>> verilog/power_stage_ctrl.sv
`timescale 1ns/100ps
`include "power_stage_defines.svh"
module power_stage_ctrl
	import power_stage_pkg::*;
#(
	parameter bit FOUR_OUTPUTS = 1'b0
) (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	input  wire logic        io_tick_i,
	input  wire logic        pll_tick_i,
	input  wire logic        clk_sel_i,
	input  wire logic        run_i,
	input  wire logic        lock_i,
	input  wire timing_set_t timing_i,
	input  wire run_mode_t   mode_i,
	input  wire logic [3:0]  polarity_i,
	input  wire logic [1:0]  dup_sel_i,
	input  wire logic        matrix_en_i,
	input  wire logic [3:0]  matrix_i,
	input  wire logic        retrigger_fault_pin_i,
	input  wire logic        comparator_i,
	input  wire logic [1:0]  in_src_sel_i,
	input  wire logic [1:0]  in_rising_i,
	input  wire logic [1:0]  in_fault_mode_i,
	input  wire logic        chain_sync_in_i,
	input  wire logic        sync_slave_i,
	input  wire logic        chain_halt_in_i,
	input  wire logic        halt_follow_i,
	input  wire logic        emergency_pin_i,
	input  wire logic        fuse_hiz_i,
	input  wire logic [2:0]  flag_clr_i,
	input  wire logic [2:0]  irq_en_i,
	output logic             stage_out_a_o,
	output logic             stage_out_a_oe_o,
	output logic             stage_out_b_o,
	output logic             stage_out_b_oe_o,
	output logic             stage_out_dup_first_o,
	output logic             stage_out_dup_first_oe_o,
	output logic             stage_out_dup_second_o,
	output logic             stage_out_dup_second_oe_o,
	output logic [11:0]      retrigger_capture_value_o,
	output logic [2:0]       flags_o,
	output logic             stage_irq_o,
	output logic             adc_sync_out_o,
	output logic             chain_sync_out_o,
	output logic             chain_halt_out_o
);
	stage_state_t r;
	stage_state_t next_r;
	logic         tick;
	logic         adv;
	logic         running;
	logic         halt;
	logic         start_ok;
	logic [1:0]   in_act;
	logic [1:0]   in_evt;
	logic         restart;
	logic         fault_ev;
	logic         fault_lvl;
	logic [11:0]  lim;
	logic [11:0]  lim_e;
	logic         last;
	logic         down;
	ramp_state_t  nxt;
	logic [3:0]   fwm_d;
	logic         ext;
	logic         at_top;
	logic         cyc_end;
	logic         load_ok;
	logic         raw_a;
	logic         raw_b;
	logic         sub_b;
	logic [3:0]   lvl;
	logic [3:0]   pin_out;
	logic [3:0]   pin_oe;

	////////////////////////////////////////////////////////////////////////////////
	// stage clock is a tick on clk_i chosen from either source
	assign tick     = clk_sel_i ? pll_tick_i : io_tick_i;
	assign adv      = ce_i & tick;
	assign running  = (r.st != S_STOP);
	assign halt     = halt_follow_i & chain_halt_in_i;
	assign start_ok = run_i & ~halt & (~sync_slave_i | chain_sync_in_i);

	////////////////////////////////////////////////////////////////////////////////
	// one input module per part
	stage_input_module u_in_a (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.ce_i      (ce_i),
		.pin_i     (retrigger_fault_pin_i),
		.comp_i    (comparator_i),
		.src_sel_i (in_src_sel_i[0]),
		.rising_i  (in_rising_i[0]),
		.active_o  (in_act[0]),
		.event_o   (in_evt[0])
	);

	stage_input_module u_in_b (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.ce_i      (ce_i),
		.pin_i     (retrigger_fault_pin_i),
		.comp_i    (comparator_i),
		.src_sel_i (in_src_sel_i[1]),
		.rising_i  (in_rising_i[1]),
		.active_o  (in_act[1]),
		.event_o   (in_evt[1])
	);

	assign restart   = running & |(in_evt & ~in_fault_mode_i);
	assign fault_ev  = |(in_evt & in_fault_mode_i);
	// any part's fault blanks both outputs: a half bridge must not keep one leg
	assign fault_lvl = |(in_act & in_fault_mode_i);

	////////////////////////////////////////////////////////////////////////////////
	// ramp limits per running mode
	always_comb begin
		lim  = r.act.reset_b[11:0];
		last = 1'b1;
		nxt  = S_STOP;
		down = 1'b0;
		case (r.mode)
			M_FOUR: begin
				case (r.st)
					S_R0: begin
						lim  = r.act.set_a + `DT4_EXTRA - `CNT_ONE;
						last = 1'b0;
						nxt  = (r.act.reset_a == `CNT_RST) ? S_R2 : S_R1;
					end
					S_R1: begin
						lim  = r.act.reset_a - `CNT_ONE;
						last = 1'b0;
						nxt  = S_R2;
					end
					S_R2: begin
						lim  = r.act.set_b + `DT4_EXTRA - `CNT_ONE;
						last = (r.act.reset_b[11:0] == `CNT_RST);
						nxt  = S_R3;
					end
					default: begin
						lim = r.act.reset_b[11:0] - `CNT_ONE;
					end
				endcase
			end
			M_TWO: begin
				if (r.st == S_R0) begin
					lim  = r.act.reset_a;
					last = 1'b0;
					nxt  = S_R1;
				end
			end
			M_CENTER: begin
				last = (r.st == S_R1);
				nxt  = S_R1;
				down = (r.st == S_R1);
			end
			default: begin
				lim = r.act.reset_b[11:0];
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// flank width modulation: bit reversed frame index spreads the long cycles
	assign fwm_d   = r.act.reset_b[`FWM_HI:`FWM_LO];
	assign ext     = ({r.frame[0], r.frame[1], r.frame[2], r.frame[3]} < fwm_d) &
	                 (r.mode != M_CENTER);
	assign lim_e   = lim + {11'h000, last & ext};
	assign at_top  = (r.cnt == lim_e);
	// cycle ends only when the last ramp ends, sub-cycle B in every mode but M_ONE
	assign cyc_end = running & adv & ~restart &
	                 (down ? (r.cnt == `CNT_RST) : (at_top & last));
	assign load_ok = (~running | cyc_end) & ~lock_i;

	////////////////////////////////////////////////////////////////////////////////
	// raw output levels per mode
	always_comb begin
		raw_a = 1'b0;
		raw_b = 1'b0;
		sub_b = 1'b0;
		case (r.mode)
			M_FOUR: begin
				raw_a = (r.st == S_R1);
				raw_b = (r.st == S_R3);
				sub_b = (r.st == S_R2) | (r.st == S_R3);
			end
			M_TWO: begin
				raw_a = (r.st == S_R0) & (r.cnt > r.act.set_a);
				raw_b = (r.st == S_R1) & (r.cnt > r.act.set_b);
				sub_b = (r.st == S_R1);
			end
			M_ONE: begin
				raw_a = (r.cnt > r.act.set_a) & (r.cnt <= r.act.reset_a);
				raw_b = (r.cnt > r.act.set_b);
			end
			M_CENTER: begin
				raw_a = (r.cnt < r.act.set_a);
				raw_b = (r.cnt >= r.act.set_b);
				sub_b = (r.st == S_R1);
			end
			default: begin
				raw_a = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// state update
	always_comb begin
		next_r          = r;
		next_r.sync_out = 1'b0;
		next_r.adc_sync = 1'b0;
		next_r.em_meta  = emergency_pin_i;
		next_r.em_sync  = r.em_meta;
		if (load_ok) begin
			next_r.act  = timing_i;
			next_r.mode = mode_i;
		end
		case (r.st)
			S_STOP: begin
				if (start_ok) begin
					next_r.st       = S_R0;
					next_r.cnt      = `CNT_RST;
					next_r.sync_out = 1'b1;
				end
			end
			S_R0, S_R1, S_R2, S_R3: begin
				if (restart) begin
					next_r.st      = S_R0;
					next_r.cnt     = `CNT_RST;
					next_r.capture = r.cnt;
				end else if (cyc_end) begin
					next_r.frame    = r.frame + 4'h1;
					next_r.cnt      = `CNT_RST;
					next_r.st       = (run_i & ~halt) ? S_R0 : S_STOP;
					next_r.sync_out = run_i & ~halt;
				end else if (adv) begin
					if (down) begin
						next_r.cnt = r.cnt - `CNT_ONE;
					end else if (!at_top) begin
						next_r.cnt = r.cnt + `CNT_ONE;
					end else begin
						next_r.st  = nxt;
						// center keeps the top value for the down ramp
						next_r.cnt = down | (r.mode == M_CENTER) ? r.cnt : `CNT_RST;
					end
				end
				next_r.adc_sync = adv & (r.st == S_R0) & (r.cnt == r.act.reset_a);
			end
			default: begin
				next_r.st = S_STOP;
			end
		endcase
		// a set in the same cycle as its clear wins
		next_r.flags                 = r.flags & ~flag_clr_i;
		next_r.flags[`FLAG_OVF]      = next_r.flags[`FLAG_OVF] | cyc_end;
		next_r.flags[`FLAG_FAULT]    = next_r.flags[`FLAG_FAULT] | fault_ev;
		next_r.flags[`FLAG_CAPT]     = next_r.flags[`FLAG_CAPT] | restart;
		next_r.out_a = running & ~fault_lvl &
		               ((FOUR_OUTPUTS & matrix_en_i) ? matrix_i[{sub_b, 1'b0}] : raw_a);
		next_r.out_b = running & ~fault_lvl &
		               ((FOUR_OUTPUTS & matrix_en_i) ? matrix_i[{sub_b, 1'b1}] : raw_b);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r          <= '0;
			r.st       <= S_STOP;
			r.mode     <= M_FOUR;
			r.fuse_hiz <= fuse_hiz_i;
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output stage
	assign lvl[0] = r.out_a;
	assign lvl[1] = r.out_b;
	assign lvl[2] = dup_sel_i[0] ? r.out_b : r.out_a;
	assign lvl[3] = dup_sel_i[1] ? r.out_b : r.out_a;

	for (genvar gi = 0; gi < 4; gi++) begin : g_drv
		stage_output_driver u_drv (
			.clk_i         (clk_i),
			.srst_i        (srst_i),
			.ce_i          (ce_i),
			.level_i       (lvl[gi]),
			.active_high_i (polarity_i[gi]),
			.emergency_i   (r.em_sync),
			.hiz_i         (r.fuse_hiz),
			.out_o         (pin_out[gi]),
			.oe_o          (pin_oe[gi])
		);
	end

	// smaller instances leave the duplicate pins undriven
	assign stage_out_a_o             = pin_out[0];
	assign stage_out_a_oe_o          = pin_oe[0];
	assign stage_out_b_o             = pin_out[1];
	assign stage_out_b_oe_o          = pin_oe[1];
	assign stage_out_dup_first_o     = pin_out[2];
	assign stage_out_dup_first_oe_o  = pin_oe[2] & FOUR_OUTPUTS;
	assign stage_out_dup_second_o    = pin_out[3];
	assign stage_out_dup_second_oe_o = pin_oe[3] & FOUR_OUTPUTS;

	assign retrigger_capture_value_o = r.capture;
	assign flags_o                   = r.flags;
	assign stage_irq_o               = |(r.flags & irq_en_i);
	assign adc_sync_out_o            = r.adc_sync;
	assign chain_sync_out_o          = r.sync_out;
	assign chain_halt_out_o          = ~running;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	a_cnt_bound: assert property (running |-> r.cnt <= lim_e)
		else $error("counter beyond ramp limit");
	a_dead_len: assert property (r.mode == M_FOUR && r.st == S_R0 && ce_i && !restart &&
		r.cnt < r.act.set_a + `CNT_ONE |=> r.st == S_R0)
		else $error("four ramp dead time ended early");
	a_on_len: assert property (r.mode == M_FOUR && r.st == S_R1 && adv && !restart &&
		r.cnt == r.act.reset_a - `CNT_ONE |=> r.st == S_R2)
		else $error("four ramp on time length wrong");
	a_update_end: assert property ($changed(r.act) |-> $past(load_ok))
		else $error("timing set changed mid cycle");
	a_capture_cnt: assert property (restart && ce_i |=>
		r.capture == $past(r.cnt) && r.cnt == `CNT_RST)
		else $error("capture value wrong");
	a_ovf_flag: assert property (cyc_end |=> r.flags[`FLAG_OVF] ##1 stage_irq_o || !irq_en_i[0]
		|| flag_clr_i[0])
		else $error("overflow flag not raised");
	a_dead_quiet: assert property (r.mode == M_FOUR && r.st == S_R0 && ce_i && !matrix_en_i
		|=> !r.out_a)
		else $error("output active in dead time");
	a_sync_start: assert property (r.st == S_STOP && start_ok && ce_i |=>
		chain_sync_out_o && r.st == S_R0 ##1 !chain_sync_out_o || !$past(ce_i))
		else $error("sync pulse missing at start");
	a_center_dir: assert property (r.mode == M_CENTER && r.st == S_R1 && adv && !restart &&
		r.cnt != `CNT_RST |=> r.cnt == $past(r.cnt) - `CNT_ONE)
		else $error("center mode not counting down");
endmodule

// >>> sim/bridge_gate_model.sv
`timescale 1ns/100ps
module bridge_gate_model (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        a_i,
	input  wire logic        a_oe_i,
	input  wire logic        b_i,
	input  wire logic        b_oe_i,
	output logic [15:0]      a_hi_o,
	output logic [15:0]      a_lo_o,
	output logic [15:0]      b_hi_o,
	output logic [15:0]      overlap_o
);
	logic        ga;
	logic        gb;
	logic        ga_q;
	logic        gb_q;
	logic [15:0] run_a;
	logic [15:0] run_b;
	////////////////////////////////////////////////////////////////////////////////
	// gate drivers have pull-downs: a released pin switches the transistor off
	assign ga = a_oe_i & a_i;
	assign gb = b_oe_i & b_i;
	////////////////////////////////////////////////////////////////////////////////
	// widths of the last finished runs; both gates on is shoot-through
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ga_q      <= 1'b0;
			gb_q      <= 1'b0;
			run_a     <= 16'h0000;
			run_b     <= 16'h0000;
			a_hi_o    <= 16'h0000;
			a_lo_o    <= 16'h0000;
			b_hi_o    <= 16'h0000;
			overlap_o <= 16'h0000;
		end else begin
			ga_q <= ga;
			gb_q <= gb;
			if (ga == ga_q) begin
				run_a <= run_a + 16'h0001;
			end else begin
				if (ga_q) a_hi_o <= run_a;
				else a_lo_o <= run_a;
				run_a <= 16'h0001;
			end
			if (gb == gb_q) begin
				run_b <= run_b + 16'h0001;
			end else begin
				if (gb_q) b_hi_o <= run_b;
				run_b <= 16'h0001;
			end
			if (ga && gb) overlap_o <= overlap_o + 16'h0001;
		end
	end
endmodule

// >>> sim/power_stage_ctrl_test.sv
`timescale 1ns/100ps
module power_stage_ctrl_test;
	import power_stage_pkg::*;
	logic        clk_i, srst_i, ce_i, io_tick_i, pll_tick_i, clk_sel_i, run_i, lock_i;
	timing_set_t timing_i;
	run_mode_t   mode_i;
	logic [3:0]  polarity_i, matrix_i;
	logic [1:0]  dup_sel_i, in_src_sel_i, in_rising_i, in_fault_mode_i;
	logic        matrix_en_i, pin_i, comparator_i, sync_in_i, sync_slave_i, halt_in_i;
	logic        halt_follow_i, emergency_i, fuse_hiz_i, any;
	logic [2:0]  flag_clr_i, irq_en_i, flags_o;
	logic        a_o, a_oe, b_o, b_oe, d1_o, d1_oe, d2_o, d2_oe, irq_o, adc_o, sync_o, halt_o;
	logic [11:0] cap_o;
	logic [15:0] a_hi, a_lo, b_hi, ovl, ovl0;
	int          err_total, checks, cycles, p, sum;
	////////////////////////////////////////////////////////////////////////////////
	power_stage_ctrl #(.FOUR_OUTPUTS(1'b1)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
		.io_tick_i(io_tick_i), .pll_tick_i(pll_tick_i), .clk_sel_i(clk_sel_i), .run_i(run_i),
		.lock_i(lock_i), .timing_i(timing_i), .mode_i(mode_i), .polarity_i(polarity_i),
		.dup_sel_i(dup_sel_i), .matrix_en_i(matrix_en_i), .matrix_i(matrix_i),
		.retrigger_fault_pin_i(pin_i), .comparator_i(comparator_i), .in_src_sel_i(in_src_sel_i),
		.in_rising_i(in_rising_i), .in_fault_mode_i(in_fault_mode_i),
		.chain_sync_in_i(sync_in_i), .sync_slave_i(sync_slave_i), .chain_halt_in_i(halt_in_i),
		.halt_follow_i(halt_follow_i), .emergency_pin_i(emergency_i), .fuse_hiz_i(fuse_hiz_i),
		.flag_clr_i(flag_clr_i), .irq_en_i(irq_en_i), .stage_out_a_o(a_o),
		.stage_out_a_oe_o(a_oe), .stage_out_b_o(b_o), .stage_out_b_oe_o(b_oe),
		.stage_out_dup_first_o(d1_o), .stage_out_dup_first_oe_o(d1_oe),
		.stage_out_dup_second_o(d2_o), .stage_out_dup_second_oe_o(d2_oe),
		.retrigger_capture_value_o(cap_o), .flags_o(flags_o), .stage_irq_o(irq_o),
		.adc_sync_out_o(adc_o), .chain_sync_out_o(sync_o), .chain_halt_out_o(halt_o));
	bridge_gate_model gate_u (.clk_i(clk_i), .srst_i(srst_i), .a_i(a_o), .a_oe_i(a_oe),
		.b_i(b_o), .b_oe_i(b_oe), .a_hi_o(a_hi), .a_lo_o(a_lo), .b_hi_o(b_hi), .overlap_o(ovl));
	////////////////////////////////////////////////////////////////////////////////
	always #20 clk_i = ~clk_i;
	// half-rate io tick so that clock selection shows in the period
	always @(posedge clk_i) io_tick_i <= #1 ~io_tick_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			$display("[ERR] %0t run did not finish in time", $time);
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// stage cycle length between two cycle-start pulses
	task automatic period(output int n);
		n = 0;
		while (sync_o !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		cyc(1);
		n = 1;
		while (sync_o !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic mode_case(input run_mode_t m, input int per, input int ahi);
		mode_i = m;
		cyc(60);
		period(p);
		check(16'(p), 16'(per));
		check(a_hi, 16'(ahi));
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 0; srst_i = 1; ce_i = 1; io_tick_i = 0; pll_tick_i = 1; clk_sel_i = 1;
		run_i = 0; lock_i = 0; timing_i = '{12'h003, 12'h005, 12'h001, 16'h0004};
		mode_i = M_FOUR; polarity_i = 4'hf; dup_sel_i = 2'b10; matrix_en_i = 0; matrix_i = 0;
		in_src_sel_i = 0; in_rising_i = 2'b11; in_fault_mode_i = 0; pin_i = 0; comparator_i = 0;
		sync_in_i = 0; sync_slave_i = 0; halt_in_i = 0; halt_follow_i = 0; emergency_i = 0;
		fuse_hiz_i = 0; flag_clr_i = 0; irq_en_i = 0; err_total = 0; checks = 0; cycles = 0;
		cyc(16);
		check(d1_oe, 1'b1);
		check({a_o, b_o, a_oe, halt_o, flags_o}, 7'h18);
		srst_i = 0; run_i = 1;
		cyc(60);
		// four ramp: dead a 5, on a 5, dead b 3, on b 4
		ovl0 = ovl;
		period(p);
		check(16'(p), 16'd17);
		check(a_hi, 16'd5);
		check(b_hi, 16'd4);
		check(a_lo, 16'd12);
		any = 0;
		sum = 0;
		repeat (17) begin
			any |= (d1_o !== a_o) | (d2_o !== b_o);
			sum += int'(adc_o);
			cyc(1);
		end
		check(any, 1'b0);
		check(16'(sum), 16'd0);
		check(ovl - ovl0, 16'h0000);
		done("four ramp");
		polarity_i = 4'he;
		cyc(40);
		check(a_lo, 16'd5);
		check(a_hi, 16'd12);
		polarity_i = 4'hf;
		done("polarity");
		mode_case(M_TWO, 11, 2);
		// two ramp first ramp (sub-cycle A) reaches the sync point once per cycle
		sum = 0;
		repeat (11) begin
			sum += int'(adc_o);
			cyc(1);
		end
		check(16'(sum), 16'd1);
		mode_case(M_ONE, 5, 1);
		mode_case(M_CENTER, 10, 6);
		mode_case(M_FOUR, 17, 5);
		done("modes");
		matrix_en_i = 1;
		matrix_i = 4'h6;
		cyc(40);
		check(a_hi, 16'd7);
		check(b_hi, 16'd10);
		matrix_en_i = 0;
		done("matrix");
		timing_i.reset_b = 16'h8004;
		cyc(60);
		sum = 0;
		repeat (16) begin
			period(p);
			sum += p;
		end
		check(16'(sum), 16'd280);
		timing_i.reset_b = 16'h0004;
		done("fwm");
		// held set must survive cycle ends while locked
		lock_i = 1;
		timing_i.reset_a = 12'h002;
		cyc(60);
		check(a_hi, 16'd5);
		lock_i = 0;
		cyc(60);
		period(p);
		check(16'(p), 16'd14);
		check(a_hi, 16'd2);
		timing_i.reset_a = 12'h005;
		cyc(60);
		done("lock");
		clk_sel_i = 0;
		cyc(80);
		period(p);
		check(16'(p), 16'd34);
		clk_sel_i = 1;
		cyc(80);
		done("clock select");
		period(p);
		cyc(2);
		ce_i = 0;
		any = 0;
		repeat (40) begin
			any |= sync_o;
			cyc(1);
		end
		ce_i = 1;
		p = 0;
		while (sync_o !== 1'b1 && p < 200) begin
			cyc(1);
			p++;
		end
		check(any, 1'b0);
		check(16'(p), 16'd15);
		done("clock enable");
		irq_en_i = 3'b100;
		// start of cycle, so the counter value at capture is known
		period(p);
		pin_i = 1;
		cyc(3);
		pin_i = 0;
		cyc(6);
		check(flags_o[2], 1'b1);
		check(cap_o, 12'h003);
		check(irq_o, 1'b1);
		flag_clr_i = 3'b100;
		cyc(1);
		flag_clr_i = 0;
		cyc(1);
		check({flags_o[2], irq_o}, 2'b00);
		irq_en_i = 3'b001;
		cyc(40);
		check({flags_o[0], irq_o}, 2'b11);
		irq_en_i = 0;
		cyc(1);
		check(irq_o, 1'b0);
		done("retrigger and flags");
		in_src_sel_i = 2'b01;
		in_fault_mode_i = 2'b01;
		comparator_i = 1;
		cyc(6);
		any = 0;
		repeat (34) begin
			any |= a_o | b_o;
			cyc(1);
		end
		check(any, 1'b0);
		check(flags_o[1], 1'b1);
		comparator_i = 0;
		cyc(6);
		in_fault_mode_i = 0;
		in_src_sel_i = 0;
		cyc(60);
		check(a_hi, 16'd5);
		done("fault");
		emergency_i = 1;
		cyc(4);
		any = 0;
		repeat (34) begin
			any |= a_o | b_o | d1_o | d2_o | ~a_oe;
			cyc(1);
		end
		check(any, 1'b0);
		emergency_i = 0;
		cyc(40);
		done("emergency");
		halt_follow_i = 1;
		halt_in_i = 1;
		cyc(40);
		check(halt_o, 1'b1);
		any = 0;
		repeat (40) begin
			any |= sync_o;
			cyc(1);
		end
		check(any, 1'b0);
		halt_in_i = 0;
		sync_slave_i = 1;
		cyc(20);
		check(halt_o, 1'b1);
		sync_in_i = 1;
		cyc(1);
		check(sync_o, 1'b1);
		sync_in_i = 0;
		sync_slave_i = 0;
		cyc(40);
		check(halt_o, 1'b0);
		done("halt");
		// second reset with the strap set for high impedance
		srst_i = 1;
		fuse_hiz_i = 1;
		cyc(16);
		srst_i = 0;
		emergency_i = 1;
		cyc(6);
		check({a_oe, b_oe, d1_oe, d2_oe}, 4'h0);
		done("high impedance");
		results();
	end
endmodule
